// *** common/strap_pkg.sv ***
// Package for the power-up strap decoder: register map, field positions,
// reset values, timing counts and carrier structs.
// Assumes a 125 MHz system clock and a classic Wishbone register bus.
package strap_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BLINK_MS = 1000;
  localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned HALL_HOLD_MS = 1000;
  localparam int unsigned HALL_HOLD_CYCLES = (CLK_HZ / 1000) * HALL_HOLD_MS;

  // ----------------------------------------------------------------
  // Identity encoding
  // ----------------------------------------------------------------
  localparam int unsigned LEVEL_COUNT = 7;
  localparam logic [2:0] LEVEL_MAX = 3'h6;
  localparam logic [2:0] SCRIPT_LEVEL_MIN = 3'h3;
  localparam logic [8:0] HIGH_WEIGHT = 9'h031;
  localparam logic [8:0] MID_WEIGHT = 9'h007;
  localparam logic [8:0] ID_LIMIT = 9'h07f;
  localparam logic [7:0] ID_ZERO_OPEN = 8'h7f;
  localparam logic [7:0] ID_UNCONFIGURED = 8'hff;

  // ----------------------------------------------------------------
  // Autorun disable word
  // ----------------------------------------------------------------
  localparam logic [15:0] NVM_AUTORUN_ADDR = 16'h4000;
  localparam logic [15:0] NVM_AUTORUN_OFF = 16'h0001;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_MOTION_ERROR = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;

  // Config register fields
  localparam int unsigned CFG_ID_LSB = 0;
  localparam int unsigned CFG_SCRIPTED_BIT = 8;
  localparam int unsigned CFG_UNCONF_BIT = 9;
  localparam int unsigned CFG_AUTORUN_BIT = 10;
  localparam int unsigned CFG_VALID_BIT = 11;
  localparam int unsigned CFG_SLAVE_BIT = 12;
  localparam int unsigned CFG_SETUP_INV_BIT = 13;

  // Interrupt events
  localparam int unsigned IRQ_WIDTH = 3;
  localparam int unsigned IRQ_CONFIG_DONE = 0;
  localparam int unsigned IRQ_PROGRAM_START = 1;
  localparam int unsigned IRQ_SETUP_INVALID = 2;

  // Motion error register field
  localparam int unsigned MOTION_ERROR_SETUP_BIT = 2;

  // Control register fields
  localparam int unsigned CTL_SETUP_LOADED_BIT = 0;

  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [15:0] MOTION_ERROR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] mid;
    logic [2:0] low;
  } strap_levels_t;

  typedef struct packed {
    logic scripted;
    logic [7:0] node_id;
    logic unconfigured;
  } node_config_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_HALL_WAIT = 3'b010,
    ST_DECIDE = 3'b011,
    ST_RUN = 3'b100,
    ST_SLAVE = 3'b101
  } boot_state_t;

endpackage

// *** core/strap_decode.sv ***
// Power-up strap decoder: samples the identity straps once, selects the
// network mode, computes the node identity and decides on automatic run.
// Assumes the level detector delivers stable 0..6 codes before release of
// reset, and that the non-volatile memory word and program status are
// presented by the memory controller as plain levels.
//
// Operation
// - Top level L0-L2 open, L3-L6 scripted
// - Each strap is a code 0..6
// - Open id is 49*high+7*mid+low
// - Open raw zero gives id 127
// - Raw above 127 gives id 255
// - Id 255 open: only LSS, silent
// - Non-configured flashes ready every second
// - Scripted id is 49*(high-3)+7*mid+low
// - Scripted raw zero gives 255, non-configured
// - Sample straps once, hold until power cycle
// - Scripted mode autoruns valid stored program
// - Word 0x0001 at 0x4000 disables autorun
// - Open mode never autoruns a program
// - Hall inputs low one second forces slave
// - No valid program forces slave state
// - Hall low on ethernet variant invalidates setup
// - Then defaults load, error bit 2 set
module strap_decode
  import strap_pkg::*;
#(
  parameter int unsigned BLINK_COUNT = BLINK_CYCLES,
  parameter int unsigned HALL_COUNT = HALL_HOLD_CYCLES,
  parameter bit ETHERNET_VARIANT = 1'b0
) (
  input wire logic clk_i, // System clock, 125 MHz
  input wire logic rst_i, // Power-on reset, active high
  input wire logic [2:0] identity_strap_low_i, // Low strap level code
  input wire logic [2:0] identity_strap_mid_i, // Mid strap level code
  input wire logic [2:0] identity_strap_high_i, // High strap level code
  input wire logic [2:0] hall_i, // Digital Hall pins
  input wire logic program_valid_i, // Stored program is valid
  input wire logic [15:0] nvm_first_word_i, // Word at autorun address
  input wire logic setup_invalid_i, // Setup table was invalidated
  input wire logic motor_supply_i, // Motor supply present
  input wire logic lss_command_i, // Incoming command is LSS
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic config_valid_o, // Mode and identity fixed
  output logic scripted_network_mode_o, // Scripted mode selected
  output logic [7:0] node_id_o, // Node identity
  output logic unconfigured_o, // LSS non-configured state
  output logic accept_command_o, // Command may be processed
  output logic tx_enable_o, // Normal transmission allowed
  output logic ready_led_o, // Ready indicator
  output logic program_start_o, // One-cycle start of program
  output logic slave_mode_o, // Non-automatic slave state
  output logic setup_invalidate_o, // Request to void setup table
  output logic irq_o // Level interrupt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    boot_state_t st;
    strap_levels_t strap_s1;
    strap_levels_t strap_s2;
    logic [2:0] hall_s1;
    logic [2:0] hall_s2;
    node_config_t cfg;
    logic valid;
    logic sampled;
    logic autorun;
    logic slave;
    logic start;
    logic started;
    logic setup_inv;
    logic setup_seen;
    logic [31:0] hall_cnt;
    logic [31:0] blink_cnt;
    logic led;
    logic accept;
    logic tx_en;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic irq;
    logic [15:0] motion_error;
    logic setup_loaded;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t r;
  state_t next_r;

  // ----------------------------------------------------------------
  // Identity arithmetic
  // ----------------------------------------------------------------
  function automatic logic [2:0] clamp_level(input logic [2:0] code);
    // Illegal code 7 is treated as the top level
    clamp_level = (code > LEVEL_MAX) ? LEVEL_MAX : code;
  endfunction

  function automatic node_config_t decode_id(input strap_levels_t s);
    logic [8:0] raw;
    logic [8:0] top;
    logic scripted;
    scripted = (s.high >= SCRIPT_LEVEL_MIN);
    top = scripted ? 9'(s.high - SCRIPT_LEVEL_MIN) : 9'(s.high);
    raw = 9'(top * HIGH_WEIGHT) + 9'(s.mid * MID_WEIGHT) + 9'(s.low);
    decode_id.scripted = scripted;
    if (raw == 9'h000) begin
      decode_id.node_id = scripted ? ID_UNCONFIGURED : ID_ZERO_OPEN;
    end else if (raw > ID_LIMIT) begin
      decode_id.node_id = ID_UNCONFIGURED;
    end else begin
      decode_id.node_id = raw[7:0];
    end
    decode_id.unconfigured = (decode_id.node_id == ID_UNCONFIGURED);
  endfunction

  function automatic logic wb_lane(input logic [31:0] old, input logic [31:0] wd,
                                   input logic [3:0] sel, input int unsigned bit_i);
    wb_lane = sel[bit_i / 8] ? wd[bit_i] : old[bit_i];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  strap_levels_t levels;
  logic wr;
  logic rd;
  logic hall_low;
  logic [IRQ_WIDTH-1:0] events;

  always_comb begin
    next_r = r;
    // Strap codes come from pins, so they pass two flip-flops first
    next_r.strap_s1.high = identity_strap_high_i;
    next_r.strap_s1.mid = identity_strap_mid_i;
    next_r.strap_s1.low = identity_strap_low_i;
    next_r.strap_s2 = r.strap_s1;
    levels.high = clamp_level(r.strap_s2.high);
    levels.mid = clamp_level(r.strap_s2.mid);
    levels.low = clamp_level(r.strap_s2.low);
    next_r.hall_s1 = hall_i;
    next_r.hall_s2 = r.hall_s1;
    hall_low = (r.hall_s2 == 3'h0);
    next_r.start = 1'b0;
    events = '0;

    unique case (r.st)
      ST_SETTLE: begin
        next_r.st = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (!r.sampled) begin
          next_r.cfg = decode_id(levels);
          next_r.sampled = 1'b1;
        end
        next_r.valid = 1'b1;
        events[IRQ_CONFIG_DONE] = 1'b1;
        next_r.hall_cnt = '0;
        next_r.st = ST_HALL_WAIT;
      end
      ST_HALL_WAIT: begin
        // Hall pins must stay low the whole hold time to count
        if (!hall_low) begin
          next_r.st = ST_DECIDE;
        end else if (r.hall_cnt >= HALL_COUNT - 1) begin
          next_r.slave = 1'b1;
          if (ETHERNET_VARIANT) begin
            next_r.setup_inv = 1'b1;
            events[IRQ_SETUP_INVALID] = 1'b1;
          end
          next_r.st = ST_DECIDE;
        end else begin
          next_r.hall_cnt = r.hall_cnt + 32'd1;
        end
      end
      ST_DECIDE: begin
        next_r.autorun = r.cfg.scripted
          && (nvm_first_word_i != NVM_AUTORUN_OFF)
          && program_valid_i && !r.slave;
        if (!program_valid_i || !r.cfg.scripted || r.slave ||
            nvm_first_word_i == NVM_AUTORUN_OFF) begin
          next_r.slave = 1'b1;
          next_r.st = ST_SLAVE;
        end else begin
          next_r.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (motor_supply_i && !r.started) begin
          next_r.start = 1'b1;
          next_r.started = 1'b1;
          events[IRQ_PROGRAM_START] = 1'b1;
        end
      end
      ST_SLAVE: begin
        next_r.st = ST_SLAVE;
      end
      default: begin
        next_r.st = ST_SETTLE;
      end
    endcase

    // Setup defaults flagged in the motion error register
    if (r.valid && setup_invalid_i && !r.setup_seen) begin
      next_r.setup_seen = 1'b1;
      next_r.motion_error[MOTION_ERROR_SETUP_BIT] = 1'b1;
    end

    // Non-configured node: LSS only, no transmission, slow blink
    next_r.accept = r.valid && (!r.cfg.unconfigured || lss_command_i);
    next_r.tx_en = r.valid && !r.cfg.unconfigured;
    if (r.valid && r.cfg.unconfigured) begin
      if (r.blink_cnt >= BLINK_COUNT - 1) begin
        next_r.blink_cnt = '0;
        next_r.led = !r.led;
      end else begin
        next_r.blink_cnt = r.blink_cnt + 32'd1;
      end
    end else begin
      next_r.blink_cnt = '0;
      next_r.led = r.valid;
    end

    // Wishbone slave, one wait state, ack drops after one cycle
    // Writes land on the ack edge, the one the master samples
    wr = wb_cyc_i && wb_stb_i && wb_we_i && r.ack;
    rd = wb_cyc_i && wb_stb_i && !r.ack;
    next_r.ack = rd;
    next_r.rdata = '0;
    if (rd && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CONFIG: begin
          next_r.rdata[CFG_ID_LSB +: 8] = r.cfg.node_id;
          next_r.rdata[CFG_SCRIPTED_BIT] = r.cfg.scripted;
          next_r.rdata[CFG_UNCONF_BIT] = r.cfg.unconfigured;
          next_r.rdata[CFG_AUTORUN_BIT] = r.autorun;
          next_r.rdata[CFG_VALID_BIT] = r.valid;
          next_r.rdata[CFG_SLAVE_BIT] = r.slave;
          next_r.rdata[CFG_SETUP_INV_BIT] = r.setup_inv;
        end
        ADDR_IRQ_STATUS: next_r.rdata[IRQ_WIDTH-1:0] = r.irq_status;
        ADDR_IRQ_MASK: next_r.rdata[IRQ_WIDTH-1:0] = r.irq_mask;
        ADDR_MOTION_ERROR: next_r.rdata[15:0] = r.motion_error;
        ADDR_CONTROL: next_r.rdata[CTL_SETUP_LOADED_BIT] = r.setup_loaded;
        default: next_r.rdata = '0;
      endcase
    end
    if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == ADDR_IRQ_STATUS) begin
        next_r.irq_status = r.irq_status & ~wb_dat_i[IRQ_WIDTH-1:0];
      end
      if (wb_adr_i == ADDR_IRQ_MASK) begin
        next_r.irq_mask = wb_dat_i[IRQ_WIDTH-1:0];
      end
      if (wb_adr_i == ADDR_CONTROL) begin
        next_r.setup_loaded = wb_dat_i[CTL_SETUP_LOADED_BIT];
      end
    end
    // Clear acts on the updated value, so a same-cycle set is cleared too
    if (wr && wb_adr_i == ADDR_MOTION_ERROR) begin
      for (int unsigned i = 0; i < 16; i++) begin
        next_r.motion_error[i] = next_r.motion_error[i] & ~wb_lane(32'h0000_0000, wb_dat_i,
                                                             wb_sel_i, i);
      end
    end
    // Events win over a clear in the same cycle
    next_r.irq_status = next_r.irq_status | events;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    // A loaded setup table withdraws the invalidate request
    if (r.setup_loaded) begin
      next_r.setup_inv = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= ST_SETTLE;
      r.irq_mask <= IRQ_MASK_RESET;
      r.motion_error <= MOTION_ERROR_RESET;
      // Strap synchroniser runs through reset so codes are settled at release
      r.strap_s1 <= next_r.strap_s1;
      r.strap_s2 <= next_r.strap_s2;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign config_valid_o = r.valid;
  assign scripted_network_mode_o = r.cfg.scripted;
  assign node_id_o = r.cfg.node_id;
  assign unconfigured_o = r.cfg.unconfigured;
  assign accept_command_o = r.accept;
  assign tx_enable_o = r.tx_en;
  assign ready_led_o = r.led;
  assign program_start_o = r.start;
  assign slave_mode_o = r.slave;
  assign setup_invalidate_o = r.setup_inv;
  assign irq_o = r.irq;

endmodule

// *** bench/strap_decode_sva.sv ***
// Checker for the strap decoder: boot sequence, frozen identity, bus handshake.
// Assumes straps stay static from reset until the sample has been taken.
module strap_decode_sva (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Power-on reset
  input wire logic [2:0] identity_strap_high_i, // High strap code
  input wire logic lss_command_i, // Command is LSS
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic config_valid_o, // Configuration fixed
  input wire logic scripted_network_mode_o, // Scripted mode
  input wire logic [7:0] node_id_o, // Node identity
  input wire logic unconfigured_o, // Non-configured state
  input wire logic accept_command_o, // Command accepted
  input wire logic tx_enable_o, // Transmission allowed
  input wire logic program_start_o, // Program start pulse
  input wire logic slave_mode_o // Slave state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence

  chk_ack_one_cycle: assert property (req_s |=> ack_pulse_s)
    else $error("ack not a single pulse one cycle after request");
  chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_valid_soon: assert property ($fell(rst_i) |-> ##[1:3] config_valid_o)
    else $error("config valid late");
  chk_valid_holds: assert property (config_valid_o |=> config_valid_o)
    else $error("config valid dropped");
  chk_cfg_frozen: assert property (config_valid_o |=> $stable(node_id_o) &&
    $stable(scripted_network_mode_o) && $stable(unconfigured_o)) else $error("config moved");
  chk_mode_top: assert property ($rose(config_valid_o) |->
    scripted_network_mode_o == (identity_strap_high_i >= 3'h3)) else $error("mode wrong");
  chk_unconf_id: assert property (config_valid_o |-> unconfigured_o == (node_id_o == 8'hff))
    else $error("non-configured flag disagrees with identity");
  chk_silent_unconf: assert property (config_valid_o && unconfigured_o && !lss_command_i
    |=> !accept_command_o && !tx_enable_o) else $error("non-configured node not silent");
  chk_start_gated: assert property (program_start_o |->
    scripted_network_mode_o && !slave_mode_o) else $error("start outside scripted run");
  chk_start_single: assert property (program_start_o |=> !program_start_o [*8])
    else $error("program started twice");
endmodule

bind strap_decode strap_decode_sva chk_u (.*);

// *** bench/strap_partner.sv ***
// Far side of the decoder: strap resistors, Hall pins, program memory,
// motor supply and a network master alternating LSS and other commands.
// Assumes case_i changes only while reset is held, except on purpose.
module strap_partner
  import strap_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Power-on reset
  input wire logic [11:0] case_i, // Straps, program, autorun word, Hall hold
  output strap_levels_t straps_o, // Strap level codes
  output logic [2:0] hall_o, // Hall pins
  output logic program_valid_o, // Stored program valid
  output logic [15:0] nvm_word_o, // Word at autorun address
  output logic motor_supply_o, // Motor supply present
  output logic lss_command_o // Command is LSS
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rot;
  logic [3:0] up_cnt;
  // Resistor levels settle long before the sample edge
  assign straps_o = case_i[11:3];
  assign program_valid_o = case_i[2];
  assign nvm_word_o = case_i[1] ? 16'h0001 : 16'h0000;
  // A turning rotor never shows all pins low, so only the strap does
  assign hall_o = case_i[0] ? 3'h0 : rot;
  // Supply comes up late so the start must wait for it
  assign motor_supply_o = (up_cnt == 4'hf);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rot <= 3'h1;
      up_cnt <= 4'h0;
      lss_command_o <= 1'b0;
    end else begin
      rot <= {rot[1:0], rot[2]};
      if (up_cnt != 4'hf) begin
        up_cnt <= up_cnt + 4'h1;
      end
      lss_command_o <= ~lss_command_o;
    end
  end
endmodule

// *** bench/test_power_up_axis_id_strap_decode.sv ***
// Testbench for the strap decoder: boots every strap case, then the registers.
// Assumes the partner model and the bound checker; short blink and Hall counts.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_power_up_axis_id_strap_decode
  import strap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, setup_invalid_i, pv, mot, lss, led_q;
  logic [11:0] case_r;
  logic [2:0] hall;
  logic [15:0] nvm;
  logic [31:0] wb_dat_o, rd;
  logic [7:0] node_id_o;
  logic wb_ack_o, config_valid_o, scripted_network_mode_o, unconfigured_o, accept_command_o;
  logic tx_enable_o, ready_led_o, program_start_o, slave_mode_o, setup_invalidate_o, irq_o;
  wb_req_t req;
  strap_levels_t straps;
  int num_errors, n_checks, n_starts, n_led;
  // Last case puts the illegal code 7 on the top strap
  logic [11:0] cases [9] = '{12'h004, 12'h534, 12'h50c, 12'h604, 12'haf4, 12'hdb6, 12'h855,
    12'h608, 12'he04};

  strap_partner part_u (.clk_i(clk_i), .rst_i(rst_i), .case_i(case_r), .straps_o(straps),
    .hall_o(hall), .program_valid_o(pv), .nvm_word_o(nvm), .motor_supply_o(mot),
    .lss_command_o(lss));
  strap_decode #(.BLINK_COUNT(20), .HALL_COUNT(10), .ETHERNET_VARIANT(1'b1)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .identity_strap_low_i(straps.low),
    .identity_strap_mid_i(straps.mid), .identity_strap_high_i(straps.high), .hall_i(hall),
    .program_valid_i(pv), .nvm_first_word_i(nvm), .setup_invalid_i(setup_invalid_i),
    .motor_supply_i(mot), .lss_command_i(lss), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .config_valid_o(config_valid_o),
    .scripted_network_mode_o(scripted_network_mode_o), .node_id_o(node_id_o),
    .unconfigured_o(unconfigured_o), .accept_command_o(accept_command_o),
    .tx_enable_o(tx_enable_o), .ready_led_o(ready_led_o), .program_start_o(program_start_o),
    .slave_mode_o(slave_mode_o), .setup_invalidate_o(setup_invalidate_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Falls of the ready lamp only happen while it flashes
  always @(posedge clk_i) begin
    led_q <= ready_led_o;
    if (rst_i || !config_valid_o) begin
      n_starts <= 0;
      n_led <= 0;
    end else begin
      n_starts <= n_starts + program_start_o;
      n_led <= n_led + (led_q && !ready_led_o);
    end
  end

  function automatic logic [7:0] exp_id(input logic [2:0] h, m, l);
    int r;
    r = (h >= 3) ? 49 * (h - 3) + 7 * m + l : 49 * h + 7 * m + l;
    if (r == 0) return (h >= 3) ? 8'hff : 8'h7f;
    return (r > 127) ? 8'hff : r[7:0];
  endfunction
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int t;
    t = 0;
    req <= '{1'b1, 1'b1, we, 4'hf, adr, wd};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    `CHK(wb_ack_o, 1'b1)
    rd = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic boot(input logic [11:0] c, input logic si);
    int t;
    t = 0;
    case_r <= c;
    setup_invalid_i <= si;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    do begin
      @(posedge clk_i);
      t++;
    end while (config_valid_o !== 1'b1 && t < 10);
    `CHK(config_valid_o, 1'b1)
    repeat (60) @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [2:0] h, m, l;
    logic [7:0] e;
    logic au;
    rst_i = 1'b1;
    case_r = '0;
    setup_invalid_i = 1'b0;
    req = '0;
    num_errors = 0;
    n_checks = 0;
    foreach (cases[i]) begin
      boot(cases[i], 1'b0);
      {h, m, l} = cases[i][11:3];
      e = exp_id(h, m, l);
      au = (h >= 3) && cases[i][2] && !cases[i][1] && !cases[i][0];
      `CHK(scripted_network_mode_o, h >= 3)
      `CHK(node_id_o, e)
      `CHK(unconfigured_o, e == 8'hff)
      `CHK(tx_enable_o, e != 8'hff)
      `CHK(accept_command_o, e != 8'hff || !lss)
      `CHK(n_led > 0, e == 8'hff)
      `CHK(slave_mode_o, !au)
      `CHK(n_starts == 1, au)
      `CHK(setup_invalidate_o, cases[i][0])
      case_r <= case_r ^ 12'he00;
      repeat (3) @(posedge clk_i);
      `CHK(node_id_o, e)
    end
    boot(12'haf4, 1'b1);
    wb(1'b0, ADDR_CONFIG, '0);
    `CHK(rd[13:0], {2'b00, 1'b1, 1'b1, 1'b0, 1'b1, 8'h7d})
    wb(1'b0, ADDR_IRQ_STATUS, '0);
    `CHK(rd[2:0], 3'h3)
    `CHK(irq_o, 1'b0)
    wb(1'b1, ADDR_IRQ_MASK, 32'h1);
    wb(1'b0, ADDR_IRQ_MASK, '0);
    `CHK(rd, 32'h1)
    `CHK(irq_o, 1'b1)
    wb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wb(1'b0, ADDR_MOTION_ERROR, '0);
    `CHK(rd[2], 1'b1)
    wb(1'b1, ADDR_MOTION_ERROR, 32'h4);
    wb(1'b0, ADDR_MOTION_ERROR, '0);
    `CHK(rd[2], 1'b0)
    wb(1'b0, 8'h20, '0);
    `CHK(rd, 32'h0)
    boot(12'h855, 1'b0);
    wb(1'b0, ADDR_IRQ_STATUS, '0);
    `CHK(rd[2], 1'b1)
    wb(1'b1, ADDR_CONTROL, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK(setup_invalidate_o, 1'b0)
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule
